// [hdl/cbr_exec_cfg.svh]
// Constants for the branch, call, rotate and increment executor.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
`ifndef CBR_EXEC_CFG_SVH
`define CBR_EXEC_CFG_SVH
// APB register byte offsets
`define CBR_OFF_CTRL 8'h00
`define CBR_OFF_PC 8'h04
`define CBR_OFF_FLAGS 8'h08
`define CBR_OFF_WORK 8'h0c
`define CBR_OFF_SHADOW 8'h10
`define CBR_OFF_STACK 8'h14
`define CBR_OFF_BANK 8'h18
`define CBR_OFF_FADDR 8'h1c
`define CBR_OFF_FDATA 8'h20
// Status flag positions
`define CBR_FLG_C 0
`define CBR_FLG_DC 1
`define CBR_FLG_Z 2
`define CBR_FLG_OV 3
`define CBR_FLG_N 4
// Opcode patterns on the upper instruction bits
`define CBR_OPC_ZBR 8'he0
`define CBR_OPC_CALL 7'h76
`define CBR_OPC_JMP 8'hef
`define CBR_OPC_ROT 6'h10
`define CBR_OPC_ONES 7'h34
`define CBR_OPC_INC 6'h0a
// Access bank split and reset values
`define CBR_ACC_SPLIT 8'h80
`define CBR_ACC_HI_BANK 4'hf
`define CBR_ACC_LO_BANK 4'h0
`define CBR_RST_PC 21'h000000
`define CBR_RST_BYTE 8'h00
`define CBR_ALL_ONES 8'hff
`define CBR_PC_STEP 21'h000002
// Phases per instruction cycle
`define CBR_PHASES 4
`endif

// [hdl/cbr_exec_pkg.sv]
// Types shared by the executor: phase and operation codes.
// Assumes the constants header is included by the design file.
package cbr_exec_pkg;
  typedef enum logic [3:0] {
    CBR_Q1 = 4'h1,
    CBR_Q2 = 4'h2,
    CBR_Q3 = 4'h4,
    CBR_Q4 = 4'h8
  } cbr_phase_t;
  typedef enum logic [6:0] {
    CBR_NOP = 7'h01,
    CBR_ZBR = 7'h02,
    CBR_CALL = 7'h04,
    CBR_JMP = 7'h08,
    CBR_ROT = 7'h10,
    CBR_ONES = 7'h20,
    CBR_INC = 7'h40
  } cbr_op_t;
endpackage

// [hdl/cbr_exec.sv]
// Executes branch-on-zero, long call, long jump, rotate, set and increment.
// Assumes program memory answers fetch_addr combinationally on instr_data.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "cbr_exec_cfg.svh"

module cbr_exec #(
  parameter int STACK_DEPTH = 31,
  parameter int BANKS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [20:0] fetch_addr,
  input wire logic [15:0] instr_data
);
  logic [20:0] pc_ff;
  logic [15:0] ir_ff;
  logic [7:0] lit_lo_ff;
  logic [11:0] lit_hi_ff;
  logic cyc2_ff;
  logic run_ff;
  logic [7:0] work_reg_ff;
  logic [4:0] flags_ff;
  logic [3:0] bank_select_reg_ff;
  logic [7:0] work_reg_shadow_ff;
  logic [4:0] flags_shadow_ff;
  logic [3:0] bank_select_shadow_ff;
  logic [7:0] opnd_ff;
  logic [7:0] res_ff;
  logic [4:0] res_flags_ff;
  logic [4:0] sp_ff;
  logic [20:0] return_stack_top_ff;
  logic [20:0] stack_mem [0:STACK_DEPTH-1];
  logic [7:0] data_mem [0:BANKS*256-1];
  logic [11:0] faddr_ff;
  logic [31:0] prdata_ff;
  cbr_exec_pkg::cbr_phase_t phase_ff;
  cbr_exec_pkg::cbr_phase_t nxt_phase;
  cbr_exec_pkg::cbr_op_t op_ff;
  cbr_exec_pkg::cbr_op_t nxt_op;

  // Phase sequencing; a stop lets a pending second cycle finish so no instruction is left half done
  always_comb begin
    case (phase_ff)
      cbr_exec_pkg::CBR_Q1: nxt_phase = (run_ff || cyc2_ff) ? cbr_exec_pkg::CBR_Q2 : cbr_exec_pkg::CBR_Q1;
      cbr_exec_pkg::CBR_Q2: nxt_phase = cbr_exec_pkg::CBR_Q3;
      cbr_exec_pkg::CBR_Q3: nxt_phase = cbr_exec_pkg::CBR_Q4;
      cbr_exec_pkg::CBR_Q4: nxt_phase = cbr_exec_pkg::CBR_Q1;
      default: nxt_phase = cbr_exec_pkg::CBR_Q1;
    endcase
  end

  wire in_q1 = (phase_ff == cbr_exec_pkg::CBR_Q1) && (run_ff || cyc2_ff);
  wire in_q2 = phase_ff == cbr_exec_pkg::CBR_Q2;
  wire in_q3 = phase_ff == cbr_exec_pkg::CBR_Q3;
  wire in_q4 = phase_ff == cbr_exec_pkg::CBR_Q4;

  // Decode of the fetched word
  wire dec_zbr = instr_data[15:8] == `CBR_OPC_ZBR;
  wire dec_call = instr_data[15:9] == `CBR_OPC_CALL;
  wire dec_jmp = instr_data[15:8] == `CBR_OPC_JMP;
  wire dec_rot = instr_data[15:10] == `CBR_OPC_ROT;
  wire dec_ones = instr_data[15:9] == `CBR_OPC_ONES;
  wire dec_inc = instr_data[15:10] == `CBR_OPC_INC;
  assign nxt_op = dec_zbr ? cbr_exec_pkg::CBR_ZBR :
                  dec_call ? cbr_exec_pkg::CBR_CALL :
                  dec_jmp ? cbr_exec_pkg::CBR_JMP :
                  dec_rot ? cbr_exec_pkg::CBR_ROT :
                  dec_ones ? cbr_exec_pkg::CBR_ONES :
                  dec_inc ? cbr_exec_pkg::CBR_INC : cbr_exec_pkg::CBR_NOP;

  wire is_zbr = op_ff == cbr_exec_pkg::CBR_ZBR;
  wire is_call = op_ff == cbr_exec_pkg::CBR_CALL;
  wire is_jmp = op_ff == cbr_exec_pkg::CBR_JMP;
  wire is_rot = op_ff == cbr_exec_pkg::CBR_ROT;
  wire is_ones = op_ff == cbr_exec_pkg::CBR_ONES;
  wire is_inc = op_ff == cbr_exec_pkg::CBR_INC;
  wire is_file = is_rot | is_ones | is_inc;
  wire dest_bit = ir_ff[9];
  wire acc_bit = ir_ff[8];
  wire save_bit = ir_ff[8];
  wire zero_now = flags_ff[`CBR_FLG_Z];
  wire zbr_taken = is_zbr && zero_now;
  wire two_cycle = zbr_taken || is_call || is_jmp;

  // Operand address from the access bank or from bank select
  wire [3:0] acc_bank = (ir_ff[7:0] < `CBR_ACC_SPLIT) ? `CBR_ACC_LO_BANK : `CBR_ACC_HI_BANK;
  wire [3:0] eff_bank = acc_bit ? bank_select_reg_ff : acc_bank;
  wire [11:0] file_addr = {eff_bank, ir_ff[7:0]};

  // Branch offset: twice the signed literal, sign extended
  wire [20:0] zbr_off = {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};
  wire [20:0] long_target = {lit_hi_ff, lit_lo_ff, 1'b0};
  wire [20:0] ret_addr = pc_ff + `CBR_PC_STEP;

  // Processing results and flags
  wire [8:0] inc_sum = {1'b0, opnd_ff} + 9'h001;
  wire [4:0] inc_flags = {inc_sum[7], opnd_ff == 8'h7f, inc_sum[7:0] == 8'h00,
                          opnd_ff[3:0] == 4'hf, inc_sum[8]};
  wire [7:0] rot_val = {opnd_ff[0], opnd_ff[7:1]};
  wire [4:0] rot_flags = {rot_val[7], flags_ff[3], rot_val == 8'h00, flags_ff[1:0]};
  wire [7:0] proc_val = is_ones ? `CBR_ALL_ONES : (is_rot ? rot_val : inc_sum[7:0]);
  wire [4:0] proc_flags = is_inc ? inc_flags : (is_rot ? rot_flags : flags_ff);

  wire file_wr = in_q4 && !cyc2_ff && is_file && (is_ones || dest_bit);
  wire work_wr = in_q4 && !cyc2_ff && (is_rot || is_inc) && !dest_bit;
  wire push_now = in_q3 && !cyc2_ff && is_call;
  wire fetch2 = in_q1 && cyc2_ff && (is_call || is_jmp);

  // APB decode; zero wait states
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == `CBR_OFF_CTRL;
  wire hit_pc = paddr == `CBR_OFF_PC;
  wire hit_flags = paddr == `CBR_OFF_FLAGS;
  wire hit_work = paddr == `CBR_OFF_WORK;
  wire hit_shadow = paddr == `CBR_OFF_SHADOW;
  wire hit_stack = paddr == `CBR_OFF_STACK;
  wire hit_bank = paddr == `CBR_OFF_BANK;
  wire hit_faddr = paddr == `CBR_OFF_FADDR;
  wire hit_fdata = paddr == `CBR_OFF_FDATA;
  wire hit_any = hit_ctrl | hit_pc | hit_flags | hit_work | hit_shadow | hit_stack |
                 hit_bank | hit_faddr | hit_fdata;
  wire [31:0] rd_word = hit_ctrl ? {31'h0, run_ff} :
                        hit_pc ? {11'h0, pc_ff} :
                        hit_flags ? {27'h0, flags_ff} :
                        hit_work ? {24'h0, work_reg_ff} :
                        hit_shadow ? {15'h0, bank_select_shadow_ff, flags_shadow_ff, work_reg_shadow_ff} :
                        hit_stack ? {6'h0, sp_ff, return_stack_top_ff} :
                        hit_bank ? {28'h0, bank_select_reg_ff} :
                        hit_faddr ? {20'h0, faddr_ff} :
                        hit_fdata ? {24'h0, data_mem[faddr_ff]} : 32'h0;
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign fetch_addr = pc_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= cbr_exec_pkg::CBR_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Fetch, decode and program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= `CBR_RST_PC;
      ir_ff <= 16'h0000;
      op_ff <= cbr_exec_pkg::CBR_NOP;
      cyc2_ff <= 1'b0;
      lit_lo_ff <= `CBR_RST_BYTE;
      lit_hi_ff <= 12'h000;
    end else begin
      if (in_q1 && !cyc2_ff) begin
        ir_ff <= instr_data;
        op_ff <= nxt_op;
        pc_ff <= pc_ff + `CBR_PC_STEP;
      end else if (fetch2) begin
        lit_hi_ff <= instr_data[11:0];
        pc_ff <= pc_ff + `CBR_PC_STEP;
      end else if (in_q4 && !cyc2_ff && zbr_taken) begin
        pc_ff <= pc_ff + zbr_off;
      end else if (in_q4 && cyc2_ff && (is_call || is_jmp)) begin
        pc_ff <= long_target;
      end
      if (in_q2 && !cyc2_ff) begin
        lit_lo_ff <= ir_ff[7:0];
      end
      if (in_q4) begin
        cyc2_ff <= !cyc2_ff && two_cycle;
      end
    end
  end

  // Operand read and processing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_ff <= `CBR_RST_BYTE;
      res_ff <= `CBR_RST_BYTE;
      res_flags_ff <= 5'h00;
    end else begin
      if (in_q2) begin
        opnd_ff <= data_mem[file_addr];
      end
      if (in_q3) begin
        res_ff <= proc_val;
        res_flags_ff <= proc_flags;
      end
    end
  end

  // Core register writes, return stack and shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_reg_ff <= `CBR_RST_BYTE;
      flags_ff <= 5'h00;
      sp_ff <= 5'h00;
      return_stack_top_ff <= `CBR_RST_PC;
      work_reg_shadow_ff <= `CBR_RST_BYTE;
      flags_shadow_ff <= 5'h00;
      bank_select_shadow_ff <= 4'h0;
    end else begin
      if (work_wr) begin
        work_reg_ff <= res_ff;
      end
      if (in_q4 && !cyc2_ff && is_file) begin
        flags_ff <= res_flags_ff;
      end
      if (push_now) begin
        return_stack_top_ff <= ret_addr;
        if (32'(sp_ff) < STACK_DEPTH) begin
          sp_ff <= sp_ff + 5'h01;
        end
        if (save_bit) begin
          work_reg_shadow_ff <= work_reg_ff;
          flags_shadow_ff <= flags_ff;
          bank_select_shadow_ff <= bank_select_reg_ff;
        end
      end
    end
  end

  // Arrays carry no reset; on a full stack a push skips stack_mem and holds sp but still loads return_stack_top_ff
  always_ff @(posedge pclk) begin
    if (push_now && 32'(sp_ff) < STACK_DEPTH) begin
      stack_mem[sp_ff] <= ret_addr;
    end
    if (file_wr) begin
      data_mem[file_addr] <= res_ff;
    end else if (apb_wr && hit_fdata) begin
      data_mem[faddr_ff] <= pwdata[7:0];
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= 1'b0;
      bank_select_reg_ff <= 4'h0;
      faddr_ff <= 12'h000;
      prdata_ff <= 32'h0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        run_ff <= pwdata[0];
      end
      if (apb_wr && hit_bank) begin
        bank_select_reg_ff <= pwdata[3:0];
      end
      if (apb_wr && hit_faddr) begin
        faddr_ff <= pwdata[11:0];
      end
      if (apb_setup) begin
        prdata_ff <= rd_word;
      end
    end
  end

  zbr_target_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && zbr_taken) |=> pc_ff == $past(pc_ff) + $past(zbr_off))
    else $error("taken zero branch target wrong");
  zbr_untaken_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_zbr && !zero_now) |=> !cyc2_ff && pc_ff == $past(pc_ff))
    else $error("untaken zero branch moved the counter");
  zbr_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && zbr_taken) |=> cyc2_ff [*4] ##1 !cyc2_ff)
    else $error("taken zero branch idle cycle wrong");
  zbr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q1 && cyc2_ff && is_zbr) |=> pc_ff == $past(pc_ff))
    else $error("idle branch cycle fetched");
  call_push_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q3 && !cyc2_ff && is_call) |=> return_stack_top_ff == $past(pc_ff) + `CBR_PC_STEP)
    else $error("call pushed wrong return address");
  shadow_save_a: assert property (@(posedge pclk) disable iff (!presetn)
    (push_now && save_bit) |=> work_reg_shadow_ff == $past(work_reg_ff) &&
      flags_shadow_ff == $past(flags_ff) && bank_select_shadow_ff == $past(bank_select_reg_ff))
    else $error("fast save did not copy registers");
  shadow_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (push_now && !save_bit) |=> $stable(work_reg_shadow_ff) && $stable(flags_shadow_ff) &&
      $stable(bank_select_shadow_ff))
    else $error("shadows changed without fast save");
  long_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && cyc2_ff && (is_call || is_jmp)) |=> pc_ff == {$past(lit_hi_ff), $past(lit_lo_ff), 1'b0})
    else $error("long literal not loaded");
  jmp_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_jmp) |=> cyc2_ff [*4] ##1 !cyc2_ff)
    else $error("long jump not two cycles");
  call_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_call) |=> cyc2_ff [*4] ##1 !cyc2_ff)
    else $error("call not two cycles");
  call_lit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q2 && !cyc2_ff && is_call) |=> lit_lo_ff == $past(ir_ff[7:0]))
    else $error("call low literal not taken");
  rot_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q3 && !cyc2_ff && is_rot) |=> res_ff == {$past(opnd_ff[0]), $past(opnd_ff[7:1])})
    else $error("rotate result wrong");
  rot_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_rot) |=> flags_ff[`CBR_FLG_C] == $past(flags_ff[`CBR_FLG_C]) &&
      flags_ff[`CBR_FLG_Z] == ($past(res_ff) == 8'h00))
    else $error("rotate flags wrong");
  work_dest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_inc && !dest_bit) |=> work_reg_ff == $past(res_ff))
    else $error("result not sent to work register");
  file_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_inc && dest_bit) |=> data_mem[$past(file_addr)] == $past(res_ff))
    else $error("result not written back");
  access_bank_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q2 && is_file && !acc_bit) |-> file_addr[11:8] == (ir_ff[7] ? `CBR_ACC_HI_BANK : `CBR_ACC_LO_BANK))
    else $error("access bank operand address wrong");
  select_bank_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q2 && is_file && acc_bit) |-> file_addr[11:8] == bank_select_reg_ff)
    else $error("bank select not used");
  ones_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q3 && !cyc2_ff && is_ones) |=> res_ff == `CBR_ALL_ONES)
    else $error("set-all-ones result wrong");
  ones_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_ones) |=> $stable(flags_ff))
    else $error("set-all-ones changed flags");
  inc_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_q4 && !cyc2_ff && is_inc) |=> flags_ff[`CBR_FLG_N] == $past(res_ff[7]) &&
      flags_ff[`CBR_FLG_C] == ($past(res_ff) == 8'h00) && flags_ff[`CBR_FLG_Z] == ($past(res_ff) == 8'h00))
    else $error("increment flags wrong");
  phase_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_q2 |=> in_q3 ##1 in_q4 ##1 (phase_ff == cbr_exec_pkg::CBR_Q1))
    else $error("phase order broken");
endmodule

// [testbench/cbr_prog_mem.sv]
// Program memory model standing on the executor's fetch port.
// Assumes the bench fills mem before the core is started.
`timescale 1ns/1ps
module cbr_prog_mem (
  input wire logic [20:0] fetch_addr,
  output logic [15:0] instr_data
);
  logic [15:0] mem [0:255];
  logic in_range;
  // Outside the image a fixed non-opcode word is shown, never a stale one
  assign in_range = (fetch_addr[20:9] == 12'h000);
  assign instr_data = in_range ? mem[fetch_addr[8:1]] : 16'hffff;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the executor: APB register access and a short program.
// Waits on pready for APB answers and assumes four pclk edges per instruction cycle.
`timescale 1ns/1ps
`include "cbr_exec_cfg.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [20:0] fetch_addr;
  logic [15:0] instr_data;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int check_count = 0;

  always #2.5 pclk = ~pclk;

  cbr_exec #(.STACK_DEPTH(31), .BANKS(16)) i_cbr_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_addr(fetch_addr), .instr_data(instr_data));
  cbr_prog_mem i_cbr_prog_mem (.fetch_addr(fetch_addr), .instr_data(instr_data));

  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // Waits on pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, data, r, e);
  endtask

  task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, addr, 32'h00000000, r, e);
    chk(name, exp, r);
  endtask

  task automatic memset(input logic [11:0] fa, input logic [7:0] d);
    wr(`CBR_OFF_FADDR, {20'h00000, fa});
    wr(`CBR_OFF_FDATA, {24'h000000, d});
  endtask

  task automatic memchk(input logic [11:0] fa, input logic [7:0] exp);
    wr(`CBR_OFF_FADDR, {20'h00000, fa});
    rdchk("data_mem", `CBR_OFF_FDATA, {24'h000000, exp});
  endtask

  task automatic test_regs();
    rdchk("pc_reset", `CBR_OFF_PC, 32'h00000000);
    rdchk("ctrl_reset", `CBR_OFF_CTRL, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000, rd, er);
    chk("unmapped_err", 32'h00000001, {31'h0, er});
    chk("unmapped_data", 32'h00000000, rd);
    wr(`CBR_OFF_BANK, 32'h00000002);
    rdchk("bank", `CBR_OFF_BANK, 32'h00000002);
  endtask

  task automatic put(input int addr, input logic [15:0] w);
    i_cbr_prog_mem.mem[addr / 2] = w;
  endtask

  // Markers at 0x20..0x25 show which words ran and which were skipped
  task automatic test_program();
    put(8'h00, 16'h6810); put(8'h02, 16'h2a10); put(8'h04, 16'he001); put(8'h06, 16'h6820);
    put(8'h08, 16'h4011); put(8'h0a, 16'he001); put(8'h0c, 16'h6921); put(8'h0e, 16'hed20);
    put(8'h10, 16'hf000); put(8'h12, 16'h6822); put(8'h40, 16'h2812); put(8'h42, 16'hec40);
    put(8'h44, 16'hf000); put(8'h46, 16'h6823); put(8'h80, 16'hef44); put(8'h82, 16'hf000);
    put(8'h84, 16'h6824); put(8'h88, 16'h6825); put(8'h8a, 16'hef45); put(8'h8c, 16'hf000);
    for (int i = 0; i < 6; i++) begin
      memset(12'h020 + 12'(i), 8'h55);
    end
    memset(12'h011, 8'hd7);
    memset(12'h012, 8'h7f);
    memset(12'h212, 8'h3c);
    memset(12'h221, 8'h55);
    wr(`CBR_OFF_CTRL, 32'h00000001);
    repeat (400) @(posedge pclk);
    wr(`CBR_OFF_CTRL, 32'h00000000);
    memchk(12'h010, 8'h00);
    memchk(12'h020, 8'h55);
    memchk(12'h011, 8'hd7);
    memchk(12'h221, 8'hff);
    memchk(12'h021, 8'h55);
    memchk(12'h212, 8'h3c);
    memchk(12'h012, 8'h7f);
    memchk(12'h022, 8'h55);
    memchk(12'h023, 8'h55);
    memchk(12'h024, 8'h55);
    memchk(12'h025, 8'hff);
    rdchk("work", `CBR_OFF_WORK, 32'h00000080);
    rdchk("flags", `CBR_OFF_FLAGS, 32'h0000001a);
    rdchk("shadow", `CBR_OFF_SHADOW, 32'h000053eb);
    rdchk("stack", `CBR_OFF_STACK, 32'h00400046);
    apb(1'b0, `CBR_OFF_PC, 32'h00000000, rd, er);
    chk("pc_loop", 32'h0000008a, rd);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_program();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    finish_test();
  end
endmodule
